// >>> core/doe_pkg.sv
package doe_pkg;

  // Activation event selections
  typedef enum logic [3:0] {
    DOE_ACT_NONE,
    DOE_ACT_COMPLETE,
    DOE_ACT_PARTIAL,
    DOE_ACT_NOREAD,
    DOE_ACT_TRIG_ON,
    DOE_ACT_TRIG_OFF,
    DOE_ACT_MULTI,
    DOE_ACT_MATCH,
    DOE_ACT_NOMATCH
  } doe_act_t;

  // Deactivation event selections
  typedef enum logic [1:0] {
    DOE_DEACT_NONE,
    DOE_DEACT_TIMEOUT,
    DOE_DEACT_TRIG_ON,
    DOE_DEACT_TRIG_OFF
  } doe_deact_t;

  localparam logic [31:0] DOE_ADDR_CTRL   = 32'h0000_0000;
  localparam logic [31:0] DOE_ADDR_TMO    = 32'h0000_0004;
  localparam logic [31:0] DOE_ADDR_STATUS = 32'h0000_0008;

  // Control word fields
  localparam int DOE_CTRL_PACT_LSB = 0;
  localparam int DOE_CTRL_SACT_LSB = 4;
  localparam int DOE_CTRL_PDEA_LSB = 8;
  localparam int DOE_CTRL_SDEA_LSB = 10;
  localparam int DOE_CTRL_ERR_BIT  = 12;
  localparam int DOE_CTRL_NC_BIT   = 13;

  localparam logic [13:0] DOE_CTRL_RESET = 14'h0000;

  // Timeout in milliseconds, counted on a 1 ms tick from a 20 MHz clock
  localparam int CLK_HZ             = 20000000;
  localparam int DOE_TICK_US        = 1000;
  localparam int DOE_TICK_CYCLES    = CLK_HZ / 1000000 * DOE_TICK_US;
  localparam logic [15:0] DOE_TMO_RESET = 16'h0032;

endpackage : doe_pkg

// >>> core/doe_tick.sv
`timescale 1ns/100ps
// Free-running divider producing a one-cycle enable pulse
module doe_tick #(
  parameter int DIV = 20000
) (
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } doe_tick_st_t;

  doe_tick_st_t st;
  doe_tick_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 32'(DIV - 1)) begin
      next_st.cnt  = 32'h0000_0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  tick_width_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.tick |=> !st.tick)
    else $error("tick lasted more than one cycle");

endmodule : doe_tick

// >>> core/doe_ctrl.sv
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
// Contract
// - None selection never activates output
// - Complete read: all selected codes read
// - Partial read: some, not all read
// - No read: phase ends with nothing
// - Trigger on fires at phase start
// - Trigger off fires at phase stop
// - Same code read consecutively twice
// - Decoded code equals verifier code
// - Decoded code differs from verifier
// - Error activates output when enabled
// - Timeout ends active pulse
// - Primary none adds no deactivation
// - Secondary none adds no deactivation
// - Trigger on/off deactivates output
// - Polarity: open or closed idle
module doe_ctrl #(
  parameter int NCODES   = 8,
  parameter int CODE_W   = 32,
  parameter int TICK_DIV = doe_pkg::DOE_TICK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Reading engine events
  input  wire logic              phase_start,
  input  wire logic              phase_stop,
  input  wire logic [NCODES-1:0] code_sel,
  input  wire logic              code_valid,
  input  wire logic [NCODES-1:0] code_type,
  input  wire logic [CODE_W-1:0] code_value,
  input  wire logic [CODE_W-1:0] verifier_code,
  input  wire logic              diag_error,
  // Switched output: high turns the output transistor on
  output logic                   out_switch,
  output logic                   out_active
);

  typedef struct packed {
    logic [13:0]       ctrl;
    logic [15:0]       tmo;
    logic [NCODES-1:0] seen;
    logic              in_phase;
    logic [CODE_W-1:0] last_code;
    logic              last_ok;
    logic              active;
    logic [15:0]       ms_cnt;
    logic [31:0]       rdata;
    logic              sw;
  } doe_st_t;

  doe_st_t st;
  doe_st_t next_st;
  logic    tick;

  doe_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (tick)
  );

  doe_pkg::doe_act_t   pact;
  doe_pkg::doe_act_t   sact;
  doe_pkg::doe_deact_t pdea;
  doe_pkg::doe_deact_t sdea;
  logic                err_en;
  logic                nc_pol;

  assign pact   = doe_pkg::doe_act_t'(st.ctrl[doe_pkg::DOE_CTRL_PACT_LSB +: 4]);
  assign sact   = doe_pkg::doe_act_t'(st.ctrl[doe_pkg::DOE_CTRL_SACT_LSB +: 4]);
  assign pdea   = doe_pkg::doe_deact_t'(st.ctrl[doe_pkg::DOE_CTRL_PDEA_LSB +: 2]);
  assign sdea   = doe_pkg::doe_deact_t'(st.ctrl[doe_pkg::DOE_CTRL_SDEA_LSB +: 2]);
  assign err_en = st.ctrl[doe_pkg::DOE_CTRL_ERR_BIT];
  assign nc_pol = st.ctrl[doe_pkg::DOE_CTRL_NC_BIT];

  // Event decode from the reading phase
  logic [NCODES-1:0] seen_now;
  logic              ev_complete;
  logic              ev_partial;
  logic              ev_noread;
  logic              ev_multi;
  logic              ev_match;
  logic              ev_nomatch;
  logic              act_p;
  logic              act_s;
  logic              deact_p;
  logic              deact_s;
  logic              tmo_hit;

  function automatic logic act_hit(input doe_pkg::doe_act_t s, input logic c, input logic p,
                                   input logic n, input logic on, input logic off,
                                   input logic m, input logic y, input logic x);
    logic r;
    r = 1'b0;
    case (s)
      doe_pkg::DOE_ACT_NONE:     r = 1'b0;
      doe_pkg::DOE_ACT_COMPLETE: r = c;
      doe_pkg::DOE_ACT_PARTIAL:  r = p;
      doe_pkg::DOE_ACT_NOREAD:   r = n;
      doe_pkg::DOE_ACT_TRIG_ON:  r = on;
      doe_pkg::DOE_ACT_TRIG_OFF: r = off;
      doe_pkg::DOE_ACT_MULTI:    r = m;
      doe_pkg::DOE_ACT_MATCH:    r = y;
      doe_pkg::DOE_ACT_NOMATCH:  r = x;
      default:                   r = 1'b0;
    endcase
    return r;
  endfunction : act_hit

  function automatic logic deact_hit(input doe_pkg::doe_deact_t s, input logic t,
                                     input logic on, input logic off);
    logic r;
    r = 1'b0;
    case (s)
      doe_pkg::DOE_DEACT_NONE:     r = 1'b0;
      doe_pkg::DOE_DEACT_TIMEOUT:  r = t;
      doe_pkg::DOE_DEACT_TRIG_ON:  r = on;
      doe_pkg::DOE_DEACT_TRIG_OFF: r = off;
      default:                     r = 1'b0;
    endcase
    return r;
  endfunction : deact_hit

  always_comb begin
    seen_now = st.seen;
    if (code_valid && st.in_phase) begin
      seen_now = st.seen | code_type;
    end
    ev_complete = phase_stop && ((seen_now & code_sel) == code_sel) && (code_sel != '0);
    ev_partial  = phase_stop && ((seen_now & code_sel) != '0) &&
                  ((seen_now & code_sel) != code_sel);
    ev_noread   = phase_stop && (seen_now == '0);
    ev_multi    = code_valid && st.last_ok && (code_value == st.last_code);
    ev_match    = code_valid && (code_value == verifier_code);
    ev_nomatch  = code_valid && (code_value != verifier_code);
    act_p = act_hit(pact, ev_complete, ev_partial, ev_noread, phase_start, phase_stop,
                    ev_multi, ev_match, ev_nomatch);
    act_s = act_hit(sact, ev_complete, ev_partial, ev_noread, phase_start, phase_stop,
                    ev_multi, ev_match, ev_nomatch);
    // Free-running tick, so the first millisecond of a pulse may be short
    tmo_hit = st.active && tick && (st.ms_cnt + 16'h0001 >= st.tmo);
    deact_p = deact_hit(pdea, tmo_hit, phase_start, phase_stop);
    deact_s = deact_hit(sdea, tmo_hit, phase_start, phase_stop);
  end

  always_comb begin
    next_st = st;
    // Phase tracking
    if (phase_start) begin
      next_st.in_phase = 1'b1;
      next_st.seen     = '0;
    end else begin
      next_st.seen = seen_now;
      if (phase_stop) begin
        next_st.in_phase = 1'b0;
      end
    end
    if (code_valid) begin
      next_st.last_code = code_value;
      next_st.last_ok   = 1'b1;
    end
    if (st.active && (deact_p || deact_s)) begin
      next_st.active = 1'b0;
      next_st.ms_cnt = 16'h0000;
    end else if (act_p || act_s || (err_en && diag_error)) begin
      // A repeat event must not stall the timer, or a held error pins the output on
      if (!st.active) begin
        next_st.ms_cnt = 16'h0000;
      end else if (tick) begin
        next_st.ms_cnt = st.ms_cnt + 16'h0001;
      end
      next_st.active = 1'b1;
    end else if (st.active && tick) begin
      next_st.ms_cnt = st.ms_cnt + 16'h0001;
    end
    next_st.sw = next_st.active ^ nc_pol;
    // APB access, zero wait states
    if (psel && penable && pwrite) begin
      if (paddr == doe_pkg::DOE_ADDR_CTRL) begin
        next_st.ctrl = pwdata[13:0];
        next_st.sw   = next_st.active ^ pwdata[doe_pkg::DOE_CTRL_NC_BIT];
      end else if (paddr == doe_pkg::DOE_ADDR_TMO) begin
        next_st.tmo = pwdata[15:0];
      end
    end
    if (psel && !penable && !pwrite) begin
      if (paddr == doe_pkg::DOE_ADDR_CTRL) begin
        next_st.rdata = {18'h00000, st.ctrl};
      end else if (paddr == doe_pkg::DOE_ADDR_TMO) begin
        next_st.rdata = {16'h0000, st.tmo};
      end else if (paddr == doe_pkg::DOE_ADDR_STATUS) begin
        next_st.rdata = {14'h0000, st.ms_cnt, st.in_phase, st.active};
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st      <= '0;
      st.ctrl <= doe_pkg::DOE_CTRL_RESET;
      st.tmo  <= doe_pkg::DOE_TMO_RESET;
    end else begin
      st <= next_st;
    end
  end

  logic addr_ok;
  assign addr_ok    = (paddr == doe_pkg::DOE_ADDR_CTRL) || (paddr == doe_pkg::DOE_ADDR_TMO) ||
                      (paddr == doe_pkg::DOE_ADDR_STATUS);
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !addr_ok;
  assign prdata     = st.rdata;
  assign out_switch = st.sw;
  assign out_active = st.active;

  sequence idle_none_s;
    pact == doe_pkg::DOE_ACT_NONE && sact == doe_pkg::DOE_ACT_NONE && !err_en;
  endsequence

  none_stays_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    idle_none_s and !st.active |=> !st.active)
    else $error("output activated with no activation selection");
  complete_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    pact == doe_pkg::DOE_ACT_COMPLETE && ev_complete && !deact_p && !deact_s |=> st.active)
    else $error("complete read did not activate");
  partial_excl_a: assert property (@(posedge clk) disable iff (!arst_n)
    ev_partial |-> !ev_complete)
    else $error("partial and complete both raised");
  noread_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    ev_noread |-> !ev_complete && !ev_partial && phase_stop)
    else $error("no read raised wrongly");
  trig_on_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    pact == doe_pkg::DOE_ACT_TRIG_ON && phase_start && !st.active |=> st.active)
    else $error("trigger on did not activate");
  trig_off_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    sact == doe_pkg::DOE_ACT_TRIG_OFF && phase_stop && !st.active |=> st.active)
    else $error("trigger off did not activate");
  multi_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    code_valid ##1 code_valid && code_value == $past(code_value) |-> ev_multi)
    else $error("repeat code not flagged");
  match_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    ev_match |-> !ev_nomatch && code_value == verifier_code)
    else $error("match decode wrong");
  nomatch_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    code_valid && code_value != verifier_code |-> ev_nomatch)
    else $error("mismatch not flagged");
  error_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    err_en && diag_error && !st.active |=> st.active)
    else $error("error did not activate output");
  timeout_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    tmo_hit && pdea == doe_pkg::DOE_DEACT_TIMEOUT |=> !st.active)
    else $error("timeout did not end pulse");
  no_deact_a: assert property (@(posedge clk) disable iff (!arst_n)
    pdea == doe_pkg::DOE_DEACT_NONE && sdea == doe_pkg::DOE_DEACT_NONE && st.active |=> st.active)
    else $error("deactivated with none selected");
  trig_deact_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.active && pdea == doe_pkg::DOE_DEACT_TRIG_OFF && phase_stop |=> !st.active)
    else $error("trigger off did not deactivate");
  polarity_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 !$past(psel) |-> out_switch == (st.active ^ nc_pol))
    else $error("switch polarity wrong");

  sequence act_rise_s;
    !st.active ##1 st.active;
  endsequence

  prim_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    act_p && !st.active |=> st.active)
    else $error("primary activation missed");
  sec_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    act_s && !st.active |=> st.active)
    else $error("secondary activation missed");
  sec_trig_on_a: assert property (@(posedge clk) disable iff (!arst_n)
    sact == doe_pkg::DOE_ACT_TRIG_ON && phase_start && !st.active |=> st.active)
    else $error("secondary trigger on did not activate");
  partial_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    pact == doe_pkg::DOE_ACT_PARTIAL && ev_partial && !st.active |=> st.active)
    else $error("partial read did not activate");
  noread_fire_a: assert property (@(posedge clk) disable iff (!arst_n)
    sact == doe_pkg::DOE_ACT_NOREAD && ev_noread && !st.active |=> st.active)
    else $error("no read did not activate");
  multi_act_a: assert property (@(posedge clk) disable iff (!arst_n)
    pact == doe_pkg::DOE_ACT_MULTI && ev_multi && !st.active |=> st.active)
    else $error("repeat read did not activate");
  match_fire_a: assert property (@(posedge clk) disable iff (!arst_n)
    sact == doe_pkg::DOE_ACT_MATCH && ev_match && !st.active |=> st.active)
    else $error("match did not activate");
  nomatch_fire_a: assert property (@(posedge clk) disable iff (!arst_n)
    pact == doe_pkg::DOE_ACT_NOMATCH && ev_nomatch && !st.active |=> st.active)
    else $error("mismatch did not activate");
  err_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    !err_en && !act_p && !act_s && !st.active |=> !st.active)
    else $error("disabled error activated output");
  tmo_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.active && tick && !deact_p && !deact_s |=> st.ms_cnt == $past(st.ms_cnt) + 16'h0001)
    else $error("pulse timer stalled");
  pulse_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    act_rise_s |-> st.ms_cnt == 16'h0000)
    else $error("pulse timer not cleared at activation");
  prim_none_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.active && pdea == doe_pkg::DOE_DEACT_NONE && !deact_s |=> st.active)
    else $error("primary none deactivated output");
  sec_none_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.active && sdea == doe_pkg::DOE_DEACT_NONE && !deact_p |=> st.active)
    else $error("secondary none deactivated output");
  start_deact_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.active && sdea == doe_pkg::DOE_DEACT_TRIG_ON && phase_start |=> !st.active)
    else $error("trigger on did not deactivate");
  first_deact_a: assert property (@(posedge clk) disable iff (!arst_n)
    st.active && (deact_p || deact_s) |=> !st.active)
    else $error("deactivation condition ignored");
  idle_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    !st.active |-> out_switch == nc_pol)
    else $error("idle switch level wrong");

endmodule : doe_ctrl

// >>> tb/doe_load.sv
`timescale 1ns/100ps
// Equipment side: a pulled-up line that the output transistor sinks low
module doe_load (
  input  wire logic out_switch,
  output logic      line_lvl
);
  assign line_lvl = ~out_switch;
endmodule : doe_load

// >>> tb/tb_digital_output_event_control.sv
`timescale 1ns/100ps
module tb_digital_output_event_control;
  localparam logic [31:0] V1 = 32'hC0DE_0001;
  localparam logic [31:0] V2 = 32'hC0DE_0002;
  typedef struct packed {
    logic [3:0]  act;
    logic [3:0]  flg;
    logic [31:0] val;
    logic        exp;
  } doe_row_t;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err, hit;
  logic [31:0] paddr, pwdata, prdata, rd, code_value;
  logic        phase_start, phase_stop, code_valid, diag_error;
  logic        out_switch, out_active, line_lvl;
  logic [7:0]  code_sel, code_type;
  int          mismatches, num_checks;
  // Flags: start, type 1 read, type 2 read, stop
  doe_row_t    rows [17] = '{
    '{4'h1, 4'hF, V2, 1'h1}, '{4'h1, 4'hD, V2, 1'h0}, '{4'h2, 4'hD, V2, 1'h1},
    '{4'h2, 4'hF, V2, 1'h0}, '{4'h3, 4'h9, V2, 1'h1}, '{4'h3, 4'hD, V2, 1'h0},
    '{4'h4, 4'h8, V2, 1'h1}, '{4'h4, 4'h1, V2, 1'h0}, '{4'h5, 4'h1, V2, 1'h1},
    '{4'h5, 4'h8, V2, 1'h0}, '{4'h6, 4'h6, V1, 1'h1}, '{4'h6, 4'h2, V2, 1'h0},
    '{4'h7, 4'h4, V2, 1'h1}, '{4'h7, 4'h2, V2, 1'h0}, '{4'h8, 4'h2, V2, 1'h1},
    '{4'h8, 4'h4, V2, 1'h0}, '{4'h0, 4'hF, V1, 1'h0}};

  doe_ctrl #(.NCODES(8), .CODE_W(32), .TICK_DIV(4)) DUT (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_start(phase_start), .phase_stop(phase_stop), .code_sel(code_sel),
    .code_valid(code_valid), .code_type(code_type), .code_value(code_value),
    .verifier_code(V1), .diag_error(diag_error), .out_switch(out_switch),
    .out_active(out_active));
  doe_load load (.out_switch(out_switch), .line_lvl(line_lvl));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // Selector: 0 start, 1 code, 2 stop, 3 error
  task automatic pulse(input int w, input logic [31:0] v, input logic [7:0] t);
    @(posedge clk);
    code_value <= v;
    code_type  <= t;
    case (w)
      0: phase_start <= 1'h1;
      1: code_valid <= 1'h1;
      2: phase_stop <= 1'h1;
      default: diag_error <= 1'h1;
    endcase
    @(posedge clk);
    {phase_start, code_valid, phase_stop, diag_error} <= 4'h0;
  endtask : pulse

  task automatic wait_idle;
    while (out_active !== 1'h0) begin
      @(posedge clk);
    end
  endtask : wait_idle

  task automatic t_regs;
    apb(1'h0, doe_pkg::DOE_ADDR_CTRL, 32'h0);
    check("ctrl_reset", rd, 32'h0);
    apb(1'h0, doe_pkg::DOE_ADDR_TMO, 32'h0);
    check("tmo_reset", rd, 32'h0000_0032);
    apb(1'h1, 32'h0000_0010, 32'hFFFF_FFFF);
    check("unmapped_wr_err", 32'(err), 32'h1);
    apb(1'h0, 32'h0000_0010, 32'h0);
    check("unmapped_rd", rd, 32'h0);
    apb(1'h1, doe_pkg::DOE_ADDR_TMO, 32'h0000_0003);
    apb(1'h0, doe_pkg::DOE_ADDR_TMO, 32'h0);
    check("tmo_rw", rd, 32'h0000_0003);
    $display("register test done");
  endtask : t_regs

  // Shift 0 puts the event in the primary field, 4 in the secondary
  task automatic run_rows(input int sh);
    foreach (rows[i]) begin
      wait_idle();
      apb(1'h1, doe_pkg::DOE_ADDR_CTRL, (32'(rows[i].act) << sh) | 32'h0000_0100);
      if (rows[i].flg[3]) pulse(0, V2, 8'h00);
      if (rows[i].flg[2]) pulse(1, V1, 8'h01);
      if (rows[i].flg[1]) pulse(1, rows[i].val, 8'h02);
      if (rows[i].flg[0]) pulse(2, V2, 8'h00);
      hit = 1'h0;
      repeat (3) begin
        @(posedge clk);
        if (out_active === 1'h1) hit = 1'h1;
      end
      check("event_act", 32'(hit), 32'(rows[i].exp));
    end
    $display("event table shift %0d done", sh);
  endtask : run_rows

  task automatic t_timeout;
    int n;
    wait_idle();
    apb(1'h1, doe_pkg::DOE_ADDR_TMO, 32'h0000_0002);
    apb(1'h1, doe_pkg::DOE_ADDR_CTRL, 32'h0000_0104);
    pulse(0, V2, 8'h00);
    n = 0;
    @(posedge clk);
    while (out_active === 1'h1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check("pulse_len_ok", 32'(n >= 4 && n <= 9), 32'h1);
    $display("timeout test done");
  endtask : t_timeout

  task automatic t_polarity;
    apb(1'h1, doe_pkg::DOE_ADDR_CTRL, 32'h0000_2304);
    @(posedge clk);
    check("nc_idle_switch", 32'(out_switch), 32'h1);
    check("nc_idle_line", 32'(line_lvl), 32'h0);
    pulse(0, V2, 8'h00);
    @(posedge clk);
    check("nc_act_switch", 32'(out_switch), 32'h0);
    repeat (20) @(posedge clk);
    check("held_active", 32'(out_active), 32'h1);
    apb(1'h0, doe_pkg::DOE_ADDR_STATUS, 32'h0);
    check("status_active", 32'(rd[0]), 32'h1);
    pulse(2, V2, 8'h00);
    @(posedge clk);
    check("stop_deact", 32'(out_active), 32'h0);
    check("nc_back_idle", 32'(out_switch), 32'h1);
    // Secondary trigger-on ends it, primary deactivation left unset
    apb(1'h1, doe_pkg::DOE_ADDR_CTRL, 32'h0000_0805);
    pulse(2, V2, 8'h00);
    repeat (20) @(posedge clk);
    check("no_primary_deact", 32'(out_active), 32'h1);
    pulse(0, V2, 8'h00);
    @(posedge clk);
    check("start_deact", 32'(out_active), 32'h0);
    $display("polarity and trigger test done");
  endtask : t_polarity

  task automatic t_error;
    apb(1'h1, doe_pkg::DOE_ADDR_CTRL, 32'h0000_1100);
    pulse(3, V2, 8'h00);
    @(posedge clk);
    check("err_act", 32'(out_active), 32'h1);
    wait_idle();
    apb(1'h1, doe_pkg::DOE_ADDR_CTRL, 32'h0000_0100);
    pulse(3, V2, 8'h00);
    @(posedge clk);
    check("err_ignored", 32'(out_active), 32'h0);
    $display("error test done");
  endtask : t_error

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Whole run is under a thousand cycles; this cuts a hang
  initial begin
    #500000;
    mismatches++;
    finish_test();
  end

  initial begin
    {arst_n, psel, penable, pwrite, phase_start, phase_stop, code_valid, diag_error} = 8'h00;
    {paddr, pwdata, code_value} = 96'h0;
    code_type = 8'h00;
    code_sel  = 8'h03;
    repeat (3) @(posedge clk);
    arst_n <= 1'h1;
    t_regs();
    run_rows(0);
    run_rows(4);
    t_timeout();
    t_polarity();
    t_error();
    finish_test();
  end
endmodule : tb_digital_output_event_control
